// File: aph_power_handshake.sv
/*
 mobile power handshake of the graphics controller on its host bus.
 assumes the stop and suspend pins come from the chipset domain and are
 pulled high when idle; bus mode and variant come from device config.
*/
// What this block does and what it assumes of the chipset
// R1: the host interface runs 4x transfers with sideband addressing.
// R2: plain PCI, 1x and 2x cycles still run over the same interface.
// R3: in PCI mode no sideband, strobe, status or power pin is relied on.
// R4: the active-low busy output is asserted whenever the device is busy.
// R5: a stop request is accepted at any time, even while busy is asserted.
// R6: a stop request warns that requests will soon go unanswered; stop issuing.
// R7: a control bit selects the 1.61 or the 0.1 busy handshake variant.
// R8: in the 1.61 variant only stop and busy are used; suspend is ignored.
// R9: in the 1.61 variant a stop request also warns that the clock will stop.
// R10: in the 0.1 variant only suspend state warns that the clock will stop.
// R11: busy is open drain: pulled to zero when asserted, released otherwise.
// R12: the chipset keeps stop and suspend driven or pulled high.
// R13: busy is released once no requests are outstanding and no work waits.
// R14: stop, suspend and busy are active low.
`timescale 1ns/100ps
module aph_power_handshake (
   input  wire logic              clk_sys,
   input  wire logic              srst,
   input  wire logic              stop_request_n,
   input  wire logic              suspend_state_n,
   input  wire aph_pkg::aph_mode_t    bus_mode,
   input  wire aph_pkg::aph_variant_t variant_sel,
   input  wire logic              work_pending,
   input  wire logic              req_issue,
   input  wire logic              req_done,
   output logic                   req_allow,
   output logic                   stop_prepared,
   output logic                   clk_stop_warn,
   output logic                   sideband_en,
   output logic                   strobe_diff_en,
   output logic                   busy_indicate_o,
   output logic                   busy_indicate_oe_n
);
   import aph_pkg::*;

   aph_state_rec_t cur;
   aph_state_rec_t next_cur;
   logic           stop_act;
   logic           sus_act;
   logic           agp_on;
   logic           issue_ok;

   // pin level low means asserted
   function automatic logic pm_asserted(input logic level_n);
      pm_asserted = ~level_n; // R14
   endfunction

   // handshake pins count only outside PCI mode
   assign agp_on   = (cur.mode != MODE_PCI); // R3
   assign stop_act = agp_on & pm_asserted(cur.stp_sync); // R12
   assign sus_act  = agp_on & pm_asserted(cur.sus_sync);

   // new requests stop as soon as a stop request is seen
   assign req_allow = (cur.state == ST_RUN) & ~stop_act; // R6
   assign issue_ok  = req_issue & req_allow;

   always_comb begin
      next_cur = cur;
      // two-stage synchronisers for the chipset pins
      next_cur.stp_meta = stop_request_n;
      next_cur.stp_sync = cur.stp_meta;
      next_cur.sus_meta = suspend_state_n;
      next_cur.sus_sync = cur.sus_meta;
      next_cur.variant  = variant_sel; // R7
      next_cur.mode     = bus_mode;
      // lane usage per mode
      next_cur.sideband_en    = (bus_mode != MODE_PCI); // R1 R2 R3
      next_cur.strobe_diff_en = (bus_mode == MODE_AGP4X); // R1
      // outstanding request count
      if (issue_ok && !(req_done && cur.outstanding != '0)) begin
         if (cur.outstanding != '1) begin
            next_cur.outstanding = cur.outstanding + 1'b1;
         end
      end else if (!issue_ok && req_done && cur.outstanding != '0) begin
         next_cur.outstanding = cur.outstanding - 1'b1;
      end
      // busy while work or requests remain, regardless of stop
      next_cur.busy = agp_on & (work_pending | (next_cur.outstanding != '0)); // R4 R5 R13
      // clock stop warning per variant
      if (cur.variant == VAR_V161) begin
         next_cur.clk_stop_warn = stop_act; // R8 R9
      end else begin
         next_cur.clk_stop_warn = sus_act; // R10
      end
      // stop preparation sequence
      unique case (cur.state)
         ST_RUN: begin
            if (stop_act) begin
               next_cur.state = ST_DRAIN; // R5 R6
            end
         end
         ST_DRAIN: begin
            if (!stop_act) begin
               next_cur.state = ST_RUN;
            end else if (next_cur.outstanding == '0) begin
               next_cur.state = ST_QUIET; // R6
            end
         end
         ST_QUIET: begin
            if (!stop_act) begin
               next_cur.state = ST_RUN;
            end
         end
         default: begin
            next_cur.state = ST_RUN;
         end
      endcase
      next_cur.prepared = (next_cur.state == ST_QUIET);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cur <= STATE_RST;
      end else begin
         cur <= next_cur;
      end
   end

   assign stop_prepared      = cur.prepared;
   assign clk_stop_warn      = cur.clk_stop_warn;
   assign sideband_en        = cur.sideband_en;
   assign strobe_diff_en     = cur.strobe_diff_en;
   // open drain: only ever drives zero
   assign busy_indicate_o    = 1'b0; // R11
   assign busy_indicate_oe_n = ~cur.busy; // R4 R11

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   property p_busy_on_work;
      (work_pending && agp_on && bus_mode != MODE_PCI) |=> !busy_indicate_oe_n;
   endproperty
   a_busy_on_work: assert property (p_busy_on_work) // R4
      else $error("busy not asserted while work pending");

   property p_busy_release;
      (!work_pending && !req_issue && cur.outstanding == '0) |=> busy_indicate_oe_n;
   endproperty
   a_busy_release: assert property (p_busy_release) // R13
      else $error("busy held with nothing outstanding");

   property p_busy_under_stop;
      (stop_act && work_pending && bus_mode == cur.mode) |=> !busy_indicate_oe_n;
   endproperty
   a_busy_under_stop: assert property (p_busy_under_stop) // R5
      else $error("busy dropped because of stop request");

   property p_stop_blocks;
      (!stop_request_n && agp_on && bus_mode == cur.mode)[*3] |-> !req_allow;
   endproperty
   a_stop_blocks: assert property (p_stop_blocks) // R6
      else $error("requests allowed after stop request");

   property p_quiet_empty;
      stop_prepared |-> (cur.outstanding == '0 && !req_allow);
   endproperty
   a_quiet_empty: assert property (p_quiet_empty) // R6
      else $error("prepared with requests outstanding");

   property p_v161_clock;
      (cur.variant == VAR_V161 && stop_act) |=> clk_stop_warn;
   endproperty
   a_v161_clock: assert property (p_v161_clock) // R9
      else $error("1.61 variant missed clock stop warning");

   property p_v161_ignores_sus;
      (cur.variant == VAR_V161 && !stop_act) |=> !clk_stop_warn;
   endproperty
   a_v161_ignores_sus: assert property (p_v161_ignores_sus) // R8
      else $error("1.61 variant reacted to suspend state");

   property p_v01_clock;
      (cur.variant == VAR_V01) |=> (clk_stop_warn == $past(sus_act));
   endproperty
   a_v01_clock: assert property (p_v01_clock) // R10
      else $error("0.1 variant clock warning not from suspend");

   property p_pci_quiet;
      (cur.mode == MODE_PCI) |-> ##1 (!clk_stop_warn && busy_indicate_oe_n);
   endproperty
   a_pci_quiet: assert property (p_pci_quiet) // R3
      else $error("power pins used in PCI mode");

   property p_mode_lanes;
      (bus_mode == MODE_AGP4X) |=> (sideband_en && strobe_diff_en);
   endproperty
   a_mode_lanes: assert property (p_mode_lanes) // R1
      else $error("4x lanes not enabled");

   property p_open_drain;
      !busy_indicate_oe_n |-> (busy_indicate_o == 1'b0);
   endproperty
   a_open_drain: assert property (p_open_drain) // R11
      else $error("busy driven high");

   property p_issue_busy;
      (req_issue && req_allow && agp_on) |=> !busy_indicate_oe_n;
   endproperty
   a_issue_busy: assert property (p_issue_busy) // R4
      else $error("busy not asserted for an issued request");

   property p_work_busy_hold;
      (!busy_indicate_oe_n && work_pending && agp_on) |=> !busy_indicate_oe_n;
   endproperty
   a_work_busy_hold: assert property (p_work_busy_hold) // R5
      else $error("busy released while work still pending");

   property p_refused_no_count;
      (req_issue && !req_allow && !req_done) |=> (cur.outstanding == $past(cur.outstanding));
   endproperty
   a_refused_no_count: assert property (p_refused_no_count) // R6
      else $error("refused request was counted");

   property p_done_count;
      (req_done && !req_issue && cur.outstanding != '0)
         |=> (cur.outstanding == $past(cur.outstanding) - 4'h1);
   endproperty
   a_done_count: assert property (p_done_count) // R13
      else $error("completed request not taken off the count");

   property p_stop_enters_drain;
      (cur.state == ST_RUN && stop_act) |=> (cur.state == ST_DRAIN);
   endproperty
   a_stop_enters_drain: assert property (p_stop_enters_drain) // R5
      else $error("stop request not followed by drain");

   property p_drain_to_quiet;
      (cur.state == ST_DRAIN && stop_act && cur.outstanding == '0) |=> stop_prepared;
   endproperty
   a_drain_to_quiet: assert property (p_drain_to_quiet) // R6
      else $error("drained but not prepared for stop");

   property p_drain_waits;
      (cur.state == ST_DRAIN && stop_act && cur.outstanding != '0 && !req_done)
         |=> !stop_prepared;
   endproperty
   a_drain_waits: assert property (p_drain_waits) // R6
      else $error("prepared before requests drained");

   property p_prepared_hold;
      (stop_prepared && stop_act) |=> stop_prepared;
   endproperty
   a_prepared_hold: assert property (p_prepared_hold) // R6
      else $error("prepared state lost while stop held");

   property p_stop_release;
      (!stop_act && cur.state != ST_RUN) |=> (cur.state == ST_RUN);
   endproperty
   a_stop_release: assert property (p_stop_release) // R5
      else $error("no return to run after stop released");

   property p_release_unprepared;
      !stop_act |=> !stop_prepared;
   endproperty
   a_release_unprepared: assert property (p_release_unprepared) // R6
      else $error("prepared without a stop request");

   property p_sync_latency;
      (stop_request_n [*2] ##1 (!stop_request_n && cur.state == ST_RUN)) |-> req_allow;
   endproperty
   a_sync_latency: assert property (p_sync_latency) // R6
      else $error("stop pin used before synchronised");

   property p_pci_lanes_off;
      (bus_mode == MODE_PCI) |=> (!sideband_en && !strobe_diff_en);
   endproperty
   a_pci_lanes_off: assert property (p_pci_lanes_off) // R3
      else $error("agp lanes enabled in pci mode");

   property p_agp2x_lanes;
      (bus_mode == MODE_AGP1X || bus_mode == MODE_AGP2X) |=> (sideband_en && !strobe_diff_en);
   endproperty
   a_agp2x_lanes: assert property (p_agp2x_lanes) // R2
      else $error("1x or 2x lane usage wrong");

   property p_pci_allows;
      (cur.mode == MODE_PCI && cur.state == ST_RUN) |-> req_allow;
   endproperty
   a_pci_allows: assert property (p_pci_allows) // R3
      else $error("requests blocked in pci mode");

   property p_pci_no_drain;
      (cur.mode == MODE_PCI && cur.state == ST_RUN) |=> (cur.state == ST_RUN);
   endproperty
   a_pci_no_drain: assert property (p_pci_no_drain) // R3
      else $error("stop pin acted on in pci mode");

   property p_v01_stop_no_warn;
      (cur.variant == VAR_V01 && stop_act && !sus_act) |=> !clk_stop_warn;
   endproperty
   a_v01_stop_no_warn: assert property (p_v01_stop_no_warn) // R10
      else $error("0.1 variant warned of clock stop on stop request");

   c_stop_while_busy: cover property (!busy_indicate_oe_n && stop_act);
   c_reach_quiet: cover property (cur.state == ST_DRAIN ##[1:20] stop_prepared);
   c_v01_suspend: cover property (cur.variant == VAR_V01 && clk_stop_warn);
   c_resume: cover property (stop_prepared ##1 req_allow);

endmodule

// File: aph_pkg.sv
/*
 package for the mobile bus power handshake block: bus modes, handshake
 variants, handshake states, the state record and its reset value.
 assumes one clock, clk_sys, and a synchronous active-high reset.
*/
package aph_pkg;

   // bus operating mode, steered by configuration
   typedef enum logic [1:0] {
      MODE_PCI   = 2'h0,
      MODE_AGP1X = 2'h1,
      MODE_AGP2X = 2'h2,
      MODE_AGP4X = 2'h3
   } aph_mode_t;

   // busy handshake variant select
   typedef enum logic {
      VAR_V161 = 1'b0,
      VAR_V01  = 1'b1
   } aph_variant_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_DRAIN,
      ST_QUIET
   } aph_state_t;

   localparam int OUT_W = 4;

   // reset values
   localparam logic         PIN_IDLE_RST = 1'b1;
   localparam aph_mode_t    MODE_RST     = MODE_PCI;
   localparam aph_variant_t VARIANT_RST  = VAR_V161;

   typedef struct packed {
      logic             stp_meta;
      logic             stp_sync;
      logic             sus_meta;
      logic             sus_sync;
      aph_variant_t     variant;
      aph_mode_t        mode;
      logic [OUT_W-1:0] outstanding;
      aph_state_t       state;
      logic             busy;
      logic             clk_stop_warn;
      logic             prepared;
      logic             sideband_en;
      logic             strobe_diff_en;
   } aph_state_rec_t;

   localparam aph_state_rec_t STATE_RST = '{
      stp_meta:       PIN_IDLE_RST,
      stp_sync:       PIN_IDLE_RST,
      sus_meta:       PIN_IDLE_RST,
      sus_sync:       PIN_IDLE_RST,
      variant:        VARIANT_RST,
      mode:           MODE_RST,
      outstanding:    '0,
      state:          ST_RUN,
      busy:           1'b0,
      clk_stop_warn:  1'b0,
      prepared:       1'b0,
      sideband_en:    1'b0,
      strobe_diff_en: 1'b0
   };

endpackage

// File: aph_chipset_model.sv
/*
 chipset-side model: drives the stop and suspend pins, resolves the busy pin.
 assumes the bench sets stop_cmd and sus_cmd; the busy pin has a pull-up.
*/
`timescale 1ns/100ps
module aph_chipset_model (
   input  wire logic stop_cmd,
   input  wire logic sus_cmd,
   input  wire logic busy_indicate_o,
   input  wire logic busy_indicate_oe_n,
   output logic      stop_request_n,
   output logic      suspend_state_n,
   output logic      busy_line
);
   // pins are always driven, high when idle and low when asserted
   assign stop_request_n  = ~stop_cmd;
   assign suspend_state_n = ~sus_cmd;
   // pull-up raises the pin whenever the device releases it
   assign busy_line = busy_indicate_oe_n ? 1'b1 : busy_indicate_o;
endmodule

// File: aph_power_handshake_test.sv
/*
 self-checking bench for the mobile power handshake block.
 assumes the chipset model on the pins; inputs change at the falling edge.
*/
`timescale 1ns/100ps
module aph_power_handshake_test;
   import aph_pkg::*;
   logic         clk_sys = 1'b0;
   logic         srst = 1'b1;
   logic         stop_cmd = 1'b0;
   logic         sus_cmd = 1'b0;
   aph_mode_t    bus_mode = MODE_AGP4X;
   aph_variant_t variant_sel = VAR_V161;
   logic         work_pending = 1'b0;
   logic         req_issue = 1'b0;
   logic         req_done = 1'b0;
   logic         stop_request_n, suspend_state_n, busy_line, req_allow, stop_prepared;
   logic         clk_stop_warn, sideband_en, strobe_diff_en, busy_o, busy_oe_n;
   logic [3:0]   st;
   int           fails = 0;
   int           checked = 0;

   always #20 clk_sys = ~clk_sys;
   assign st = {req_allow, clk_stop_warn, stop_prepared, busy_line};

   aph_chipset_model chipset (.stop_cmd(stop_cmd), .sus_cmd(sus_cmd),
      .busy_indicate_o(busy_o), .busy_indicate_oe_n(busy_oe_n),
      .stop_request_n(stop_request_n), .suspend_state_n(suspend_state_n),
      .busy_line(busy_line));
   aph_power_handshake DUT (.clk_sys(clk_sys), .srst(srst),
      .stop_request_n(stop_request_n), .suspend_state_n(suspend_state_n),
      .bus_mode(bus_mode), .variant_sel(variant_sel), .work_pending(work_pending),
      .req_issue(req_issue), .req_done(req_done), .req_allow(req_allow),
      .stop_prepared(stop_prepared), .clk_stop_warn(clk_stop_warn),
      .sideband_en(sideband_en), .strobe_diff_en(strobe_diff_en),
      .busy_indicate_o(busy_o), .busy_indicate_oe_n(busy_oe_n));

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic pulse(input bit issue);
      req_issue = issue;
      req_done = ~issue;
      cyc(1);
      req_issue = 1'b0;
      req_done = 1'b0;
   endtask

   task automatic t_modes;
      bus_mode = MODE_PCI;
      cyc(2);
      chk({1'b0, sideband_en, strobe_diff_en, busy_o}, 4'h0);
      for (int m = 0; m < 4; m++) begin
         bus_mode = aph_mode_t'(m);
         cyc(2);
         chk({2'b00, sideband_en, strobe_diff_en}, {2'b00, m != 0, m == 3});
      end
      $display("modes done");
   endtask

   task automatic t_busy;
      pulse(1'b1);
      cyc(1);
      chk(st, 4'h8);
      pulse(1'b0);
      cyc(1);
      chk(st, 4'h9);
      work_pending = 1'b1;
      cyc(2);
      chk(st, 4'h8);
      bus_mode = MODE_PCI;
      stop_cmd = 1'b1;
      cyc(4);
      chk(st, 4'h9);
      stop_cmd = 1'b0;
      work_pending = 1'b0;
      bus_mode = MODE_AGP4X;
      cyc(4);
      $display("busy done");
   endtask

   task automatic t_stop_v161;
      sus_cmd = 1'b1;
      cyc(4);
      chk(st, 4'h9);
      sus_cmd = 1'b0;
      pulse(1'b1);
      stop_cmd = 1'b1;
      cyc(4);
      chk(st, 4'h4);
      pulse(1'b1);
      cyc(1);
      pulse(1'b0);
      cyc(2);
      chk(st, 4'h7);
      stop_cmd = 1'b0;
      cyc(4);
      chk(st, 4'h9);
      $display("stop 1.61 done");
   endtask

   task automatic t_stop_v01;
      variant_sel = VAR_V01;
      cyc(1);
      stop_cmd = 1'b1;
      cyc(5);
      chk(st, 4'h3);
      sus_cmd = 1'b1;
      cyc(4);
      chk(st, 4'h7);
      sus_cmd = 1'b0;
      stop_cmd = 1'b0;
      cyc(4);
      chk(st, 4'h9);
      $display("stop 0.1 done");
   endtask

   task automatic t_reset;
      pulse(1'b1);
      stop_cmd = 1'b1;
      cyc(4);
      srst = 1'b1;
      cyc(2);
      chk(st, 4'h9);
      chk({1'b0, sideband_en, strobe_diff_en, busy_oe_n}, 4'h1);
      srst = 1'b0;
      stop_cmd = 1'b0;
      cyc(2);
      chk(st, 4'h9);
      $display("reset done");
   endtask

   task automatic tally_and_finish;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      cyc(6);
      srst = 1'b0;
      cyc(1);
      t_modes();
      t_busy();
      t_stop_v161();
      t_stop_v01();
      t_reset();
      tally_and_finish();
   end

   initial begin
      #(40 * 400);
      fails++;
      tally_and_finish();
   end
endmodule
